// ===== rtl/ssr_defines.svh
// constants for the synchronous serial receiver
// assumes inclusion by ssr_pkg, ssr_receiver, the bench and the assertion module
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// ==========================================================
// widths
`define SSR_DATA_W 12
`define SSR_BASE_W 8
`define SSR_LEN_CODE_W 3
`define SSR_LEN_W 4

// ==========================================================
// character length codes
`define SSR_CODE_6 3'h1
`define SSR_CODE_7 3'h2
`define SSR_CODE_8 3'h3
`define SSR_CODE_10 3'h5
`define SSR_CODE_11 3'h6
`define SSR_CODE_12 3'h7

// ==========================================================
// character lengths in bits
`define SSR_LEN_6 4'h6
`define SSR_LEN_7 4'h7
`define SSR_LEN_8 4'h8
`define SSR_LEN_10 4'hA
`define SSR_LEN_11 4'hB
`define SSR_LEN_12 4'hC

// ==========================================================
// reset values and other data constants
`define SSR_ZERO_DATA 12'h000
`define SSR_ONE_DATA 12'h001
`define SSR_BASE_MASK 12'h0FF
`define SSR_FULL_MASK 12'hFFF
`define SSR_RESET_CODE 3'h3

`endif

// ===== rtl/ssr_pkg.sv
// types shared by the synchronous serial receiver
// assumes ssr_defines.svh is on the include path
`include "ssr_defines.svh"

package ssr_pkg;

    // ======================================================
    // program control, latched by rx_status_load
    typedef struct packed {
        logic [`SSR_LEN_CODE_W-1:0] char_len_code;
        logic rx_irq_enable;
        logic sync_discard;
    } ssr_ctrl_type;

    // ======================================================
    // receive status seen by the program
    typedef struct packed {
        logic parity_odd;
        logic overrun;
        logic active;
        logic sync_found;
        logic rx_done;
    } ssr_status_type;

    // ======================================================
    // hunt states
    typedef enum logic [2:0] {
        SSR_HUNT = 3'b001,
        SSR_FIRST = 3'b010,
        SSR_ACTIVE = 3'b100
    } ssr_state_type;

endpackage

// ===== rtl/ssr_receiver.sv
// receive half of a synchronous serial line interface
// assumes a modem bit clock far slower than clk and
// program control bits presented as plain ports
`include "ssr_defines.svh"

// Functional notes
// - each bit clock shifts in at length position
// - compare assembled character with sync every bit clock
// - need second sync straight after the first
// - first sync: load buffer, set sync found
// - each load clears register, loads one marker
// - marker at end completes next character
// - second sync sets active with the load
// - done only on loads while already active
// - discard option suppresses done for sync characters
// - receive interrupt when enabled and done
// - buffer read returns data, clears done
// - done-setting load while done still set and not being read flags overrun
// - overrun with status enable requests interrupt
// - ones counter gives parity at completion
// - buffer twelve bits with expander, else eight
// - length is three-bit code, low bit first
// - sync discard is a writable control bit
// - init clear resets every register and flag except the expander strap and the link synchronisers
// - sync pattern eight or twelve bits wide
module ssr_receiver
    import ssr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // bus initialisation
    input wire logic init_clear,
    // modem link
    input wire logic rx_bit_clock,
    input wire logic rx_serial_data,
    // option strap
    input wire logic expander_fitted,
    // program control
    input wire ssr_pkg::ssr_ctrl_type ctrl_in,
    input wire logic rx_status_load,
    input wire logic [`SSR_DATA_W-1:0] sync_pattern_in,
    input wire logic sync_pattern_load,
    input wire logic active_clear,
    input wire logic status_irq_enable,
    // program read
    input wire logic buffer_read_select,
    output logic [`SSR_DATA_W-1:0] receive_buffer,
    // status and events
    output ssr_pkg::ssr_status_type status,
    output logic sync_match,
    output logic char_load_pulse,
    output logic rx_irq,
    output logic status_irq
);
    import ssr_pkg::*;

    // ======================================================
    // helpers
    function automatic logic [`SSR_LEN_W-1:0] len_of(
        input logic [`SSR_LEN_CODE_W-1:0] code,
        input logic wide
    );
        logic [`SSR_LEN_W-1:0] len;
        len = `SSR_LEN_8;
        unique case (code)
            `SSR_CODE_6: len = `SSR_LEN_6;
            `SSR_CODE_7: len = `SSR_LEN_7;
            `SSR_CODE_10: len = wide ? `SSR_LEN_10 : `SSR_LEN_8;
            `SSR_CODE_11: len = wide ? `SSR_LEN_11 : `SSR_LEN_8;
            `SSR_CODE_12: len = wide ? `SSR_LEN_12 : `SSR_LEN_8;
            default: len = `SSR_LEN_8;
        endcase
        return len;
    endfunction

    function automatic logic [`SSR_DATA_W-1:0] mask_of(
        input logic [`SSR_LEN_W-1:0] len
    );
        logic [`SSR_DATA_W-1:0] m;
        m = ~(`SSR_FULL_MASK << len);
        return m;
    endfunction

    function automatic logic [`SSR_DATA_W-1:0] top_bit(
        input logic [`SSR_LEN_W-1:0] len
    );
        logic [`SSR_DATA_W-1:0] b;
        b = `SSR_ONE_DATA << (len - `SSR_LEN_W'(1));
        return b;
    endfunction

    // ======================================================
    // declarations
    ssr_ctrl_type ctrl_r;
    logic [`SSR_DATA_W-1:0] sync_r;
    logic expander_r;
    logic init_seen_r;
    ssr_state_type state_r;
    ssr_state_type state_nxt;
    logic [`SSR_DATA_W-1:0] shift_r;
    logic [`SSR_DATA_W-1:0] shift_nxt;
    logic [`SSR_DATA_W-1:0] assembled;
    logic [`SSR_DATA_W-1:0] len_mask;
    logic [`SSR_DATA_W-1:0] buf_mask;
    logic [`SSR_LEN_W-1:0] char_len;
    logic [`SSR_DATA_W-1:0] buffer_r;
    logic done_r;
    logic overrun_r;
    logic parity_r;
    logic ones_r;
    logic load_r;
    logic bit_clk;
    logic bit_edge;
    logic bit_data;
    logic last_bit;
    logic match;
    logic load;
    logic report;

    // ======================================================
    // link synchronisers
    ssr_sync3 u_clk_sync (
        .clk(clk),
        .reset(reset),
        .async_in(rx_bit_clock),
        .level(bit_clk),
        .rise(bit_edge)
    );

    ssr_sync3 u_data_sync (
        .clk(clk),
        .reset(reset),
        .async_in(rx_serial_data),
        .level(bit_data),
        .rise()
    );

    // ======================================================
    // expander strap caught after reset release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            expander_r <= 1'b0;
            init_seen_r <= 1'b0;
        end else if (!init_seen_r) begin
            expander_r <= expander_fitted;
            init_seen_r <= 1'b1;
        end
    end

    // ======================================================
    // control register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_r <= '{`SSR_RESET_CODE, 1'b0, 1'b0};
        end else if (init_clear) begin
            ctrl_r <= '{`SSR_RESET_CODE, 1'b0, 1'b0};
        end else if (rx_status_load) begin
            ctrl_r <= ctrl_in;
        end
    end

    // ======================================================
    // sync pattern register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_r <= `SSR_ZERO_DATA;
        end else if (init_clear) begin
            sync_r <= `SSR_ZERO_DATA;
        end else if (sync_pattern_load) begin
            sync_r <= sync_pattern_in & buf_mask;
        end
    end

    // ======================================================
    // assembly and comparison
    assign char_len = len_of(ctrl_r.char_len_code, expander_r);
    assign len_mask = mask_of(char_len);
    assign buf_mask = expander_r ? `SSR_FULL_MASK : `SSR_BASE_MASK;
    // new bit enters at the top of the character
    assign assembled = ((shift_r >> 1) |
        (bit_data ? top_bit(char_len) : `SSR_ZERO_DATA))
        & len_mask;
    assign last_bit = shift_r[0];
    assign match = bit_edge &&
        (assembled == (sync_r & len_mask));

    // character completes on first sync or after marker
    always_comb begin
        load = 1'b0;
        unique case (state_r)
            SSR_HUNT: load = match;
            SSR_FIRST: load = bit_edge && last_bit;
            SSR_ACTIVE: load = bit_edge && last_bit;
        endcase
    end

    assign report = (state_r == SSR_ACTIVE) &&
        !(ctrl_r.sync_discard && match);

    // ======================================================
    // hunt state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SSR_HUNT: begin
                if (match) begin
                    state_nxt = SSR_FIRST;
                end
            end
            SSR_FIRST: begin
                if (load) begin
                    state_nxt = match ? SSR_ACTIVE : SSR_HUNT;
                end
            end
            SSR_ACTIVE: state_nxt = SSR_ACTIVE;
        endcase
        if (active_clear) begin
            state_nxt = SSR_HUNT;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= SSR_HUNT;
        end else if (init_clear) begin
            state_r <= SSR_HUNT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ======================================================
    // shift register
    always_comb begin
        shift_nxt = shift_r;
        if (active_clear) begin
            shift_nxt = `SSR_ZERO_DATA;
        end else if (load) begin
            // cleared and loaded with the marker in the same clock
            shift_nxt = top_bit(char_len);
        end else if (bit_edge) begin
            shift_nxt = assembled;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shift_r <= `SSR_ZERO_DATA;
        end else if (init_clear) begin
            shift_r <= `SSR_ZERO_DATA;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // ======================================================
    // receive buffer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            buffer_r <= `SSR_ZERO_DATA;
        end else if (init_clear) begin
            buffer_r <= `SSR_ZERO_DATA;
        end else if (load) begin
            buffer_r <= assembled & buf_mask;
        end
    end

    // ======================================================
    // receive done, set wins over read
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done_r <= 1'b0;
        end else if (init_clear) begin
            done_r <= 1'b0;
        end else if (load && report) begin
            done_r <= 1'b1;
        end else if (buffer_read_select) begin
            done_r <= 1'b0;
        end
    end

    // ======================================================
    // overrun, cleared by init or control load
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            overrun_r <= 1'b0;
        end else if (init_clear) begin
            overrun_r <= 1'b0;
        end else if (load && report && done_r &&
            !buffer_read_select) begin
            overrun_r <= 1'b1;
        end else if (rx_status_load) begin
            overrun_r <= 1'b0;
        end
    end

    // ======================================================
    // parity counting
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ones_r <= 1'b0;
            parity_r <= 1'b0;
        end else if (init_clear || active_clear) begin
            ones_r <= 1'b0;
            parity_r <= 1'b0;
        end else if (load) begin
            parity_r <= ones_r ^ bit_data;
            ones_r <= 1'b0;
        end else if (bit_edge && bit_data) begin
            ones_r <= !ones_r;
        end
    end

    // ======================================================
    // load event
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            load_r <= 1'b0;
        end else begin
            load_r <= load && !init_clear;
        end
    end

    // ======================================================
    // outputs
    assign receive_buffer = buffer_r;
    assign status = '{parity_r, overrun_r, state_r == SSR_ACTIVE,
        state_r != SSR_HUNT, done_r};
    assign sync_match = match;
    assign char_load_pulse = load_r;
    assign rx_irq = ctrl_r.rx_irq_enable && done_r;
    assign status_irq = status_irq_enable && overrun_r;

endmodule

// ===== rtl/ssr_sync3.sv
// three-stage synchroniser with agreement filter and rise pulse
// assumes an input asynchronous to clk
module ssr_sync3 (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // raw input
    input wire logic async_in,
    // filtered outputs
    output logic level,
    output logic rise
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    // ======================================================
    // capture chain
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // ======================================================
    // accept a change once stages two and three agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            level_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end

    assign level = level_r;
    assign rise = (s2_r == s3_r) && s3_r && !level_r;

endmodule

// ===== verif/ssr_modem.sv
// modem model: bit clock and serial data, first bit lowest
// assumes one bench process calls send at a time
module ssr_modem (
    // link
    output logic bit_clk,
    output logic data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        bit_clk = 1'b0;
        data = 1'b0;
    end
    // clock still between frames, released data inverted
    task automatic send(input logic [11:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            data = v[i];
            #100 bit_clk = 1'b1;
            #100 bit_clk = 1'b0;
        end
        #20 data = ~data;
    endtask
endmodule

// ===== verif/ssr_receiver_bench.sv
// self-checking bench for the serial receiver
// assumes ssr_modem on the link and the bound checker
`include "ssr_defines.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    error_cnt++; $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
    end end
module ssr_receiver_bench;
    import ssr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, reset = 1'b1, init_clear = 1'b0;
    logic expander_fitted = 1'b1, rx_status_load = 1'b0;
    logic sync_pattern_load = 1'b0, active_clear = 1'b0;
    logic status_irq_enable = 1'b0, buffer_read_select = 1'b0;
    logic [`SSR_DATA_W-1:0] sync_pattern_in = 12'h000, receive_buffer;
    ssr_ctrl_type ctrl_in = '0;
    ssr_status_type status;
    logic rx_bit_clock, rx_serial_data, sync_match, char_load_pulse;
    logic rx_irq, status_irq;
    int checks = 0, error_cnt = 0, cycles = 0;
    // ========
    // design and modem
    ssr_receiver u_ssr_receiver (.clk(clk), .reset(reset),
        .init_clear(init_clear), .rx_bit_clock(rx_bit_clock),
        .rx_serial_data(rx_serial_data), .expander_fitted(expander_fitted),
        .ctrl_in(ctrl_in), .rx_status_load(rx_status_load),
        .sync_pattern_in(sync_pattern_in),
        .sync_pattern_load(sync_pattern_load), .active_clear(active_clear),
        .status_irq_enable(status_irq_enable),
        .buffer_read_select(buffer_read_select),
        .receive_buffer(receive_buffer), .status(status),
        .sync_match(sync_match), .char_load_pulse(char_load_pulse),
        .rx_irq(rx_irq), .status_irq(status_irq));
    ssr_modem u_ssr_modem (.bit_clk(rx_bit_clock), .data(rx_serial_data));
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // ========
    // access tasks
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge clk);
        #2;
    endtask
    task automatic prog(input logic [11:0] pat, input logic [2:0] code,
            input logic disc);
        tick();
        sync_pattern_in = pat;
        ctrl_in = '{code, 1'b1, disc};
        sync_pattern_load = 1'b1;
        rx_status_load = 1'b1;
        tick();
        sync_pattern_load = 1'b0;
        rx_status_load = 1'b0;
    endtask
    task automatic rx(input logic [11:0] v, input int n);
        u_ssr_modem.send(v, n);
        repeat (8) tick();
    endtask
    task automatic rd(input logic [11:0] exp);
        tick();
        buffer_read_select = 1'b1;
        `CHK(receive_buffer, exp)
        tick();
        buffer_read_select = 1'b0;
        `CHK(status.rx_done, 1'b0)
        `CHK(rx_irq, 1'b0)
    endtask
    task automatic frame(input logic [2:0] code, input int n,
            input logic [11:0] pat, input logic [11:0] dat);
        logic [11:0] m;
        m = 12'hFFF >> (12 - n);
        tick();
        init_clear = 1'b1;
        tick();
        init_clear = 1'b0;
        prog(pat, code, 1'b0);
        rx(12'h000, n);
        rx(pat, n);
        `CHK(status.sync_found, 1'b1)
        `CHK(status.active, 1'b0)
        `CHK(receive_buffer, pat & m)
        rx(pat, n);
        `CHK(status.active, 1'b1)
        `CHK(status.rx_done, 1'b0)
        rx(dat, n);
        `CHK(receive_buffer, dat & m)
        `CHK(status.rx_done, 1'b1)
        `CHK(rx_irq, 1'b1)
        `CHK(status.parity_odd, ^(dat & m))
        $display("frame with length code %0d done", code);
    endtask
    // ========
    // tests
    initial begin
        repeat (5) @(posedge clk);
        #2 reset = 1'b0;
        tick();
        `CHK(status, 5'h00)
        `CHK(receive_buffer, 12'h000)
        frame(3'h3, 8, 12'h096, 12'h05B);
        rd(12'h05B);
        rx(12'h096, 8);
        `CHK(status.rx_done, 1'b1)
        rd(12'h096);
        prog(12'h096, 3'h3, 1'b1);
        rx(12'h096, 8);
        `CHK(status.rx_done, 1'b0)
        rx(12'h03C, 8);
        `CHK(status.parity_odd, 1'b0)
        rx(12'h001, 8);
        `CHK(status.overrun, 1'b1)
        `CHK(status_irq, 1'b0)
        tick();
        status_irq_enable = 1'b1;
        #1;
        `CHK(status_irq, 1'b1)
        rd(12'h001);
        prog(12'h096, 3'h3, 1'b0);
        `CHK(status.overrun, 1'b0)
        tick();
        active_clear = 1'b1;
        tick();
        active_clear = 1'b0;
        `CHK(status.sync_found, 1'b0)
        rx(12'h096, 8);
        `CHK(status.sync_found, 1'b1)
        `CHK(status.active, 1'b0)
        $display("main sequence done");
        frame(3'h1, 6, 12'h016, 12'h5A5);
        frame(3'h2, 7, 12'h016, 12'h5A5);
        frame(3'h5, 10, 12'h296, 12'h5A5);
        frame(3'h6, 11, 12'h296, 12'h5A5);
        frame(3'h7, 12, 12'hA96, 12'h5A5);
        frame(3'h4, 8, 12'h096, 12'h0C3);
        tick();
        expander_fitted = 1'b0;
        reset = 1'b1;
        tick();
        reset = 1'b0;
        frame(3'h7, 8, 12'hF96, 12'h1A5);
        close_out();
    end
endmodule

// ===== verif/ssr_receiver_sva.sv
// assertions on the serial receiver ports
// assumes binding into the ssr_receiver top module
`include "ssr_defines.svh"
module ssr_receiver_sva
    import ssr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // design inputs
    input wire logic init_clear,
    input wire logic rx_bit_clock,
    input wire logic rx_serial_data,
    input wire logic expander_fitted,
    input wire ssr_pkg::ssr_ctrl_type ctrl_in,
    input wire logic rx_status_load,
    input wire logic [`SSR_DATA_W-1:0] sync_pattern_in,
    input wire logic sync_pattern_load,
    input wire logic active_clear,
    input wire logic status_irq_enable,
    input wire logic buffer_read_select,
    // design outputs
    input wire logic [`SSR_DATA_W-1:0] receive_buffer,
    input wire ssr_pkg::ssr_status_type status,
    input wire logic sync_match,
    input wire logic char_load_pulse,
    input wire logic rx_irq,
    input wire logic status_irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    // ========
    // hunt and sync
    match_pulse_a:
        assert property (sync_match |=> !sync_match)
        else $error("sync match held");
    first_sync_a:
        assert property (sync_match && !status.sync_found && !init_clear
            && !active_clear |=> status.sync_found && char_load_pulse)
        else $error("first sync not loaded");
    second_sync_a:
        assert property ($rose(status.active) |->
            $past(status.sync_found) && char_load_pulse)
        else $error("active without second sync");
    active_hold_a:
        assert property (status.active && !active_clear && !init_clear
            |=> status.active)
        else $error("active dropped");
    restart_hunt_a:
        assert property (active_clear && !init_clear
            |=> !status.active && !status.sync_found)
        else $error("hunt not restarted");
    // ========
    // done, overrun, interrupts
    done_active_a:
        assert property ($rose(status.rx_done) |->
            $past(status.active) && char_load_pulse)
        else $error("done without active load");
    read_clear_a:
        assert property (buffer_read_select && !init_clear
            |=> !status.rx_done || char_load_pulse)
        else $error("read left done set");
    overrun_set_a:
        assert property ($rose(status.overrun) |->
            $past(status.rx_done) && char_load_pulse)
        else $error("overrun without pending done");
    rx_irq_a:
        assert property (rx_irq |-> status.rx_done)
        else $error("receive request without done");
    status_irq_a:
        assert property (status_irq == (status_irq_enable
            && status.overrun))
        else $error("status request wrong");
    init_clear_a:
        assert property (init_clear |=> status == '0
            && receive_buffer == '0 && !char_load_pulse)
        else $error("init clear incomplete");
endmodule

bind ssr_receiver ssr_receiver_sva u_ssr_receiver_sva (
    .clk(clk), .reset(reset), .init_clear(init_clear),
    .rx_bit_clock(rx_bit_clock), .rx_serial_data(rx_serial_data),
    .expander_fitted(expander_fitted), .ctrl_in(ctrl_in),
    .rx_status_load(rx_status_load), .sync_pattern_in(sync_pattern_in),
    .sync_pattern_load(sync_pattern_load), .active_clear(active_clear),
    .status_irq_enable(status_irq_enable),
    .buffer_read_select(buffer_read_select),
    .receive_buffer(receive_buffer), .status(status),
    .sync_match(sync_match), .char_load_pulse(char_load_pulse),
    .rx_irq(rx_irq), .status_irq(status_irq)
);
